// >>> verilog/otpcs_ctrl.sv
// OTP controller status, transfer setup and FIFO data port
`timescale 1ns/1ns
module otpcs_ctrl import otpcs_pkg::*; #(
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Register port
  input  wire logic [31:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             irq,
  // Bus master address and DMA enable for transfers
  output logic      [31:0] master_addr,
  output logic             dma_enable,
  // Macrocell side
  output logic      [2:0]  cell_mode,
  output logic      [12:0] cell_addr,
  output logic             cell_rd_req,
  input  wire logic        cell_rd_ack,
  input  wire logic [31:0] cell_rd_data,
  output logic             cell_wr_req,
  output logic      [31:0] cell_wr_data,
  input  wire logic        cell_wr_ack,
  input  wire logic        cell_wr_fail,
  output logic             test_start,
  input  wire logic        test_done,
  input  wire logic        test_fail
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef enum logic [2:0] {ST_IDLE, ST_RD, ST_WR, ST_TEST, ST_DONE} otpcs_state_e;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // ==========================================================
  // State
  otpcs_state_e     st_ff, nxt_st;
  logic [31:0]      mem [DEPTH];
  logic [PW-1:0]    wp_ff, nxt_wp, rp_ff, nxt_rp;
  logic [CW-1:0]    cnt_ff, nxt_cnt;
  logic [4:0]       mode_ff, nxt_mode;
  logic [29:0]      mbadr_ff, nxt_mbadr;
  logic [12:0]      celadr_ff, nxt_celadr;
  logic [12:0]      nwords_ff, nxt_nwords;
  logic [12:0]      remain_ff, nxt_remain;
  logic [31:0]      ffrd_ff, nxt_ffrd;
  logic [31:0]      rdata_ff, nxt_rdata;
  logic             ardy_ff, nxt_ardy;
  logic             trdy_ff, nxt_trdy;
  logic             prdy_ff, nxt_prdy;
  logic             terr_ff, nxt_terr;
  logic             perr_ff, nxt_perr;
  logic [2:0]       irqst_ff, nxt_irqst;
  logic [2:0]       irqmsk_ff, nxt_irqmsk;
  logic             irq_ff, nxt_irq;
  logic             rdreq_ff, nxt_rdreq;
  logic             wrreq_ff, nxt_wrreq;
  logic [31:0]      wrdat_ff, nxt_wrdat;
  logic             tst_ff, nxt_tst;
  logic             push, pop;
  logic [31:0]      push_data;
  logic [2:0]       ev;
  logic [31:0]      status;
  logic             full, empty, dma, sel;
  logic [2:0]       md;

  assign full  = (cnt_ff == CW'(DEPTH));
  assign empty = (cnt_ff == '0);
  assign md    = mode_ff[2:0];
  assign dma   = mode_ff[OTPCS_MODE_DMA_BIT];
  assign sel   = mode_ff[OTPCS_MODE_SEL_BIT];

  // Status word assembly
  always_comb begin
    status = '0;
    status[OTPCS_ST_REMAIN_LSB +: 13] = remain_ff;
    status[OTPCS_ST_FILL_LSB +: 4]    = 4'(cnt_ff);
    status[OTPCS_ST_ARDY]             = ardy_ff;
    status[OTPCS_ST_TERR]             = terr_ff;
    status[OTPCS_ST_TRDY]             = trdy_ff;
    status[OTPCS_ST_PERR]             = perr_ff;
    status[OTPCS_ST_PRDY]             = prdy_ff;
  end

  // ==========================================================
  // Next-state logic for registers, FIFO and sequencer
  always_comb begin
    nxt_st     = st_ff;
    nxt_mode   = mode_ff;
    nxt_mbadr  = mbadr_ff;
    nxt_celadr = celadr_ff;
    nxt_nwords = nwords_ff;
    nxt_remain = remain_ff;
    nxt_ffrd   = ffrd_ff;
    nxt_rdata  = '0;
    nxt_ardy   = ardy_ff;
    nxt_trdy   = trdy_ff;
    nxt_prdy   = prdy_ff;
    nxt_terr   = terr_ff;
    nxt_perr   = perr_ff;
    nxt_irqmsk = irqmsk_ff;
    nxt_rdreq  = rdreq_ff;
    nxt_wrreq  = wrreq_ff;
    nxt_wrdat  = wrdat_ff;
    nxt_tst    = 1'b0;
    push       = 1'b0;
    pop        = 1'b0;
    push_data  = reg_wdata;
    ev         = '0;

    // Software writes
    if (reg_wr) begin
      unique case (reg_addr)
        OTPCS_MODE_ADDR: begin
          nxt_mode = reg_wdata[4:0];
          nxt_st   = ST_IDLE;
          nxt_rdreq = 1'b0;
          nxt_wrreq = 1'b0;
          nxt_ardy = OTPCS_RST_RDY;
          nxt_prdy = OTPCS_RST_RDY;
          nxt_trdy = OTPCS_RST_RDY;
          if (reg_wdata[2:0] != OTPCS_MODE_STBY) begin
            nxt_st = ST_DONE;                 // Start takes effect next cycle
          end
        end
        OTPCS_MBADR_ADDR:  nxt_mbadr  = reg_wdata[31:2];
        OTPCS_CELADR_ADDR: nxt_celadr = reg_wdata[12:0];
        OTPCS_NWORDS_ADDR: nxt_nwords = reg_wdata[12:0];
        OTPCS_IRQMSK_ADDR: nxt_irqmsk = reg_wdata[2:0];
        OTPCS_FFPRT_ADDR: begin
          // Port writes only in program modes with DMA off; full drops them
          if (!dma && !full && (md == OTPCS_MODE_AUTO_PG || md == OTPCS_MODE_MAN_PG)) begin
            push = 1'b1;
          end
        end
        default: ;
      endcase
    end

    // Software reads, data one cycle later
    if (reg_rd) begin
      unique case (reg_addr)
        OTPCS_MODE_ADDR:   nxt_rdata = {27'h0, mode_ff};
        OTPCS_STAT_ADDR:   nxt_rdata = status;
        OTPCS_MBADR_ADDR:  nxt_rdata = {mbadr_ff, 2'h0};
        OTPCS_CELADR_ADDR: nxt_rdata = {19'h0, celadr_ff};
        OTPCS_NWORDS_ADDR: nxt_rdata = {19'h0, nwords_ff};
        OTPCS_FFRD_ADDR:   nxt_rdata = ffrd_ff;
        OTPCS_IRQST_ADDR:  nxt_rdata = {29'h0, irqst_ff};
        OTPCS_IRQMSK_ADDR: nxt_rdata = {29'h0, irqmsk_ff};
        OTPCS_FFPRT_ADDR: begin
          // Empty read returns zero and leaves FIFO untouched
          if (!dma && !empty && md == OTPCS_MODE_AUTO_RD) begin
            pop       = 1'b1;
            nxt_rdata = mem[rp_ff];
            nxt_ffrd  = mem[rp_ff];
          end
        end
        default: nxt_rdata = '0;
      endcase
    end

    // Sequencer
    unique case (st_ff)
      ST_IDLE: ;
      ST_DONE: begin
        // Launch the selected mode
        unique case (md)
          OTPCS_MODE_AUTO_RD: begin
            nxt_ardy   = 1'b0;
            nxt_remain = nwords_ff + 13'h1;
            nxt_st     = ST_RD;
          end
          OTPCS_MODE_AUTO_PG: begin
            nxt_ardy   = 1'b0;
            nxt_perr   = 1'b0;
            // Port select streams words with no count; the register stays as is
            nxt_remain = sel ? remain_ff : nwords_ff + 13'h1;
            nxt_st     = ST_WR;
          end
          OTPCS_MODE_MAN_PG: begin
            nxt_perr = 1'b0;
            nxt_st   = ST_WR;
          end
          OTPCS_MODE_BLANK, OTPCS_MODE_DECODE, OTPCS_MODE_WR_TEST: begin
            nxt_trdy = 1'b0;
            nxt_tst  = 1'b1;
            nxt_st   = ST_TEST;
          end
          default: nxt_st = ST_IDLE;
        endcase
      end
      ST_RD: begin
        // Fetch only while the FIFO has room, so software stalls the read
        if (rdreq_ff && cell_rd_ack) begin
          nxt_rdreq  = 1'b0;
          push       = 1'b1;
          push_data  = cell_rd_data;
          nxt_celadr = celadr_ff + 13'h1;
          nxt_remain = remain_ff - 13'h1;
          if (remain_ff == 13'h1) begin
            nxt_ardy = 1'b1;
            ev[OTPCS_IRQ_AUTO] = 1'b1;
            nxt_st   = ST_IDLE;
          end
        end else if (!rdreq_ff && !full && !reg_wr) begin
          nxt_rdreq = 1'b1;
        end
      end
      ST_WR: begin
        if (wrreq_ff) begin
          if (cell_wr_ack) begin
            nxt_wrreq  = 1'b0;
            nxt_prdy   = 1'b1;
            // Error may toggle per word; sticky so the final value is the verdict
            nxt_perr   = perr_ff | cell_wr_fail;
            nxt_celadr = celadr_ff + 13'h1;
            if (md == OTPCS_MODE_MAN_PG) begin
              ev[OTPCS_IRQ_PROG] = 1'b1;
              nxt_st = ST_IDLE;
            end else if (!sel) begin
              nxt_remain = remain_ff - 13'h1;
              if (remain_ff == 13'h1) begin
                nxt_ardy = 1'b1;
                ev[OTPCS_IRQ_AUTO] = 1'b1;
                nxt_st   = ST_IDLE;
              end
            end
          end
        end else if (!empty && !push) begin
          pop       = 1'b1;
          nxt_wrdat = mem[rp_ff];
          nxt_wrreq = 1'b1;
          nxt_prdy  = 1'b0;
        end
      end
      ST_TEST: begin
        if (test_done) begin
          nxt_terr = test_fail;
          nxt_trdy = 1'b1;
          ev[OTPCS_IRQ_TEST] = 1'b1;
          nxt_st   = ST_IDLE;
        end
      end
      default: nxt_st = ST_IDLE;
    endcase

    // Interrupt status: hardware set wins over write-one-clear
    nxt_irqst = irqst_ff;
    if (reg_wr && reg_addr == OTPCS_IRQST_ADDR) begin
      nxt_irqst = irqst_ff & ~reg_wdata[2:0];
    end
    nxt_irqst = nxt_irqst | ev;
    nxt_irq   = |(nxt_irqst & nxt_irqmsk);
  end

  // FIFO pointer and count updates
  always_comb begin
    nxt_wp  = push ? ptr_inc(wp_ff) : wp_ff;
    nxt_rp  = pop ? ptr_inc(rp_ff) : rp_ff;
    nxt_cnt = cnt_ff;
    if (push && !pop) begin
      nxt_cnt = cnt_ff + 1'b1;
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_ff     <= ST_IDLE;
      wp_ff     <= '0;
      rp_ff     <= '0;
      cnt_ff    <= '0;
      mode_ff   <= '0;
      mbadr_ff  <= '0;
      celadr_ff <= OTPCS_RST_13;
      nwords_ff <= OTPCS_RST_13;
      remain_ff <= OTPCS_RST_13;
      ffrd_ff   <= OTPCS_RST_WORD;
      rdata_ff  <= OTPCS_RST_WORD;
      ardy_ff   <= OTPCS_RST_RDY;
      trdy_ff   <= OTPCS_RST_RDY;
      prdy_ff   <= OTPCS_RST_RDY;
      terr_ff   <= 1'b0;
      perr_ff   <= 1'b0;
      irqst_ff  <= '0;
      irqmsk_ff <= '0;
      irq_ff    <= 1'b0;
      rdreq_ff  <= 1'b0;
      wrreq_ff  <= 1'b0;
      wrdat_ff  <= OTPCS_RST_WORD;
      tst_ff    <= 1'b0;
    end else begin
      st_ff     <= nxt_st;
      wp_ff     <= nxt_wp;
      rp_ff     <= nxt_rp;
      cnt_ff    <= nxt_cnt;
      mode_ff   <= nxt_mode;
      mbadr_ff  <= nxt_mbadr;
      celadr_ff <= nxt_celadr;
      nwords_ff <= nxt_nwords;
      remain_ff <= nxt_remain;
      ffrd_ff   <= nxt_ffrd;
      rdata_ff  <= nxt_rdata;
      ardy_ff   <= nxt_ardy;
      trdy_ff   <= nxt_trdy;
      prdy_ff   <= nxt_prdy;
      terr_ff   <= nxt_terr;
      perr_ff   <= nxt_perr;
      irqst_ff  <= nxt_irqst;
      irqmsk_ff <= nxt_irqmsk;
      irq_ff    <= nxt_irq;
      rdreq_ff  <= nxt_rdreq;
      wrreq_ff  <= nxt_wrreq;
      wrdat_ff  <= nxt_wrdat;
      tst_ff    <= nxt_tst;
    end
  end

  // FIFO storage, no reset needed on data words
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_ff] <= push_data;
    end
  end

  // ==========================================================
  // Outputs, all straight from flops
  assign reg_rdata    = rdata_ff;
  assign irq          = irq_ff;
  assign master_addr  = {mbadr_ff, 2'h0};
  assign dma_enable   = mode_ff[OTPCS_MODE_DMA_BIT];
  assign cell_mode    = mode_ff[2:0];
  assign cell_addr    = celadr_ff;
  assign cell_rd_req  = rdreq_ff;
  assign cell_wr_req  = wrreq_ff;
  assign cell_wr_data = wrdat_ff;
  assign test_start   = tst_ff;
endmodule

// >>> include/otpcs_pkg.sv
// Constants for the OTP controller status, transfer and FIFO port block
package otpcs_pkg;
  // ==========================================================
  // Register byte addresses
  localparam logic [31:0] OTPCS_MODE_ADDR   = 32'h4000_8000;
  localparam logic [31:0] OTPCS_STAT_ADDR   = 32'h4000_8008;
  localparam logic [31:0] OTPCS_MBADR_ADDR  = 32'h4000_800C;
  localparam logic [31:0] OTPCS_CELADR_ADDR = 32'h4000_8010;
  localparam logic [31:0] OTPCS_NWORDS_ADDR = 32'h4000_8014;
  localparam logic [31:0] OTPCS_FFPRT_ADDR  = 32'h4000_8018;
  localparam logic [31:0] OTPCS_FFRD_ADDR   = 32'h4000_801C;
  localparam logic [31:0] OTPCS_IRQST_ADDR  = 32'h4000_8020;
  localparam logic [31:0] OTPCS_IRQMSK_ADDR = 32'h4000_8024;
  // ==========================================================
  // Status field positions
  localparam int OTPCS_ST_REMAIN_LSB = 16;
  localparam int OTPCS_ST_FILL_LSB   = 8;
  localparam int OTPCS_ST_ARDY       = 4;
  localparam int OTPCS_ST_TERR       = 3;
  localparam int OTPCS_ST_TRDY       = 2;
  localparam int OTPCS_ST_PERR       = 1;
  localparam int OTPCS_ST_PRDY       = 0;
  // ==========================================================
  // Mode register fields and mode codes
  localparam int OTPCS_MODE_DMA_BIT = 3;
  localparam int OTPCS_MODE_SEL_BIT = 4;
  localparam logic [2:0] OTPCS_MODE_STBY  = 3'h0;
  localparam logic [2:0] OTPCS_MODE_AUTO_RD = 3'h1;
  localparam logic [2:0] OTPCS_MODE_AUTO_PG = 3'h2;
  localparam logic [2:0] OTPCS_MODE_MAN_PG  = 3'h3;
  localparam logic [2:0] OTPCS_MODE_BLANK   = 3'h4;
  localparam logic [2:0] OTPCS_MODE_DECODE  = 3'h5;
  localparam logic [2:0] OTPCS_MODE_WR_TEST = 3'h6;
  // ==========================================================
  // Interrupt bits and reset values
  localparam int OTPCS_IRQ_AUTO = 0;
  localparam int OTPCS_IRQ_TEST = 1;
  localparam int OTPCS_IRQ_PROG = 2;
  localparam logic [31:0] OTPCS_RST_WORD = 32'h0000_0000;
  localparam logic [12:0] OTPCS_RST_13   = 13'h0000;
  localparam logic        OTPCS_RST_RDY  = 1'b1;
endpackage

// >>> tb/otpcs_ctrl_assertions.sv
// Checker for the OTP status, transfer and FIFO port block
`timescale 1ns/1ns
module otpcs_ctrl_chk import otpcs_pkg::*; #(
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // Register port
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // Transfer and macrocell side
  input wire logic [31:0] master_addr,
  input wire logic [12:0] cell_addr,
  input wire logic        cell_rd_req,
  input wire logic        cell_rd_ack,
  input wire logic        cell_wr_req,
  input wire logic        cell_wr_ack,
  input wire logic [31:0] cell_wr_data,
  input wire logic        test_start
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // Steps of a transfer
  sequence s_rd_word;
    cell_rd_req && cell_rd_ack;
  endsequence
  sequence s_test_launch;
    reg_wr && reg_addr == OTPCS_MODE_ADDR && reg_wdata[2:0] inside {[3'h4:3'h6]};
  endsequence
  // Register writes exclude aborts, which may drop requests
  a_mbadr_word_align: assert property (reg_wr && reg_addr == OTPCS_MBADR_ADDR |=>
    master_addr == {$past(reg_wdata[31:2]), 2'b00}) else $error("master address wrong");
  a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside answer cycle");
  a_celadr_step: assert property (s_rd_word |=> cell_addr == $past(cell_addr) + 13'h1)
    else $error("cell address did not advance");
  a_celadr_hold: assert property (!cell_rd_ack && !cell_wr_ack && !reg_wr |=> $stable(cell_addr))
    else $error("cell address moved without a word");
  a_rdreq_held: assert property (cell_rd_req && !cell_rd_ack && !reg_wr |=> cell_rd_req)
    else $error("read request dropped early");
  a_rdreq_drop: assert property (s_rd_word |=> !cell_rd_req)
    else $error("read request held after answer");
  a_wrdata_stable: assert property (cell_wr_req && !cell_wr_ack && !reg_wr |=>
    cell_wr_req && $stable(cell_wr_data)) else $error("program word unstable");
  a_test_launch: assert property (s_test_launch |-> ##[1:3] test_start)
    else $error("test not launched");
  a_start_pulse: assert property (test_start |=> !test_start)
    else $error("test start longer than one cycle");
endmodule
bind otpcs_ctrl otpcs_ctrl_chk #(.DEPTH(DEPTH)) i_chk (
  .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .master_addr(master_addr), .cell_addr(cell_addr),
  .cell_rd_req(cell_rd_req), .cell_rd_ack(cell_rd_ack), .cell_wr_req(cell_wr_req),
  .cell_wr_ack(cell_wr_ack), .cell_wr_data(cell_wr_data), .test_start(test_start));

// >>> tb/otpcs_cell_model.sv
// Behavioural macrocell answering read, program and test requests
`timescale 1ns/1ns
module otpcs_cell_model (
  // Clock, reset and bench controls
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        stall,
  input  wire logic        fail,
  // Macrocell interface
  input  wire logic [12:0] cell_addr,
  input  wire logic        cell_rd_req,
  output logic             cell_rd_ack,
  output logic      [31:0] cell_rd_data,
  input  wire logic        cell_wr_req,
  output logic             cell_wr_ack,
  output logic             cell_wr_fail,
  input  wire logic        test_start,
  output logic             test_done,
  output logic             test_fail
);
  logic [1:0]  wait_cnt;
  logic [2:0]  test_cnt;
  logic [31:0] word;
  // Address sits in the word so a misplaced read shows
  assign word         = {16'hC0DE, 3'h0, cell_addr};
  // Junk outside the answer, never a stale copy
  assign cell_rd_data = cell_rd_ack ? word : ~word;
  assign cell_wr_fail = cell_wr_ack & fail;
  assign test_fail    = test_done & fail;
  // Four cycles per word; stall freezes every answer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wait_cnt    <= 2'h0;
      test_cnt    <= 3'h0;
      cell_rd_ack <= 1'b0;
      cell_wr_ack <= 1'b0;
      test_done   <= 1'b0;
    end else begin
      cell_rd_ack <= 1'b0;
      cell_wr_ack <= 1'b0;
      test_done   <= 1'b0;
      if ((cell_rd_req || cell_wr_req) && !cell_rd_ack && !cell_wr_ack && !stall) begin
        wait_cnt    <= wait_cnt + 2'h1;
        cell_rd_ack <= cell_rd_req && wait_cnt == 2'h3;
        cell_wr_ack <= cell_wr_req && wait_cnt == 2'h3;
      end
      if (test_start) begin
        test_cnt <= 3'h5;
      end else if (test_cnt != 3'h0 && !stall) begin
        test_cnt  <= test_cnt - 3'h1;
        test_done <= test_cnt == 3'h1;
      end
    end
  end
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the OTP status, transfer and FIFO port block
`timescale 1ns/1ns
module tb_top import otpcs_pkg::*;;
  localparam int D = 4;
  logic        clk, nrst, reg_wr, reg_rd, irq, dma_enable, stall, fail, cell_rd_req, cell_rd_ack;
  logic        cell_wr_req, cell_wr_ack, cell_wr_fail, test_start, test_done, test_fail;
  logic [2:0]  cell_mode;
  logic [12:0] cell_addr;
  logic [31:0] reg_addr, reg_wdata, reg_rdata, master_addr, cell_rd_data, cell_wr_data, st;
  int          bad_count, check_count;
  otpcs_ctrl #(.DEPTH(D)) i_dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .master_addr(master_addr),
    .dma_enable(dma_enable), .cell_mode(cell_mode), .cell_addr(cell_addr), .cell_rd_req(cell_rd_req),
    .cell_rd_ack(cell_rd_ack), .cell_rd_data(cell_rd_data), .cell_wr_req(cell_wr_req),
    .cell_wr_data(cell_wr_data), .cell_wr_ack(cell_wr_ack), .cell_wr_fail(cell_wr_fail),
    .test_start(test_start), .test_done(test_done), .test_fail(test_fail));
  otpcs_cell_model i_cell (.clk(clk), .nrst(nrst), .stall(stall), .fail(fail), .cell_addr(cell_addr),
    .cell_rd_req(cell_rd_req), .cell_rd_ack(cell_rd_ack), .cell_rd_data(cell_rd_data),
    .cell_wr_req(cell_wr_req), .cell_wr_ack(cell_wr_ack), .cell_wr_fail(cell_wr_fail),
    .test_start(test_start), .test_done(test_done), .test_fail(test_fail));
  // ==========================================================
  // Bus tasks
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic logic [31:0] pat(input logic [12:0] a);
    return {16'hC0DE, 3'h0, a};
  endfunction
  task automatic wrap_up();
    if (bad_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask
  // Strobe drops after its edge; one idle edge avoids a double drive
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [31:0] a);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 st = reg_rdata;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [31:0] a, input logic [31:0] e, input string n);
    rd(a);
    chk(n, e, st);
  endtask
  // Poll until masked value matches, bounded
  task automatic wt(input logic [31:0] a, input logic [31:0] m, input logic [31:0] v);
    int n = 0;
    rd(a);
    while ((st & m) !== v && n < 300) begin
      rd(a);
      n++;
    end
    if ((st & m) !== v) begin
      chk("wait", v, st & m);
      wrap_up();
    end
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    nrst = 1'b0;
    reg_addr = 32'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    stall = 1'b0;
    fail = 1'b0;
    bad_count = 0;
    check_count = 0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    rchk(OTPCS_STAT_ADDR, 32'h0000_0015, "status");
    rchk(OTPCS_FFRD_ADDR, 32'h0, "read value");
    rchk(32'h4000_8004, 32'h0, "unmapped");
    wr(OTPCS_MBADR_ADDR, 32'hFFFF_FFFF);
    rchk(OTPCS_MBADR_ADDR, 32'hFFFF_FFFC, "master address");
    chk("master pins", 32'hFFFF_FFFC, master_addr);
    wr(OTPCS_NWORDS_ADDR, 32'hFFFF_FFFF);
    rchk(OTPCS_NWORDS_ADDR, 32'h0000_1FFF, "word count");
    wr(OTPCS_IRQMSK_ADDR, 32'h7);
    // Auto read of two words from cell 5
    wr(OTPCS_CELADR_ADDR, 32'h5);
    wr(OTPCS_NWORDS_ADDR, 32'h1);
    wr(OTPCS_MODE_ADDR, 32'h1);
    wt(OTPCS_STAT_ADDR, 32'h10, 32'h0);
    wt(OTPCS_STAT_ADDR, 32'h10, 32'h10);
    rchk(OTPCS_STAT_ADDR, 32'h0000_0215, "status after read");
    chk("irq", 32'h1, {31'h0, irq});
    rchk(OTPCS_CELADR_ADDR, 32'h7, "cell address");
    rchk(OTPCS_NWORDS_ADDR, 32'h1, "word count kept");
    rchk(OTPCS_FFPRT_ADDR, pat(13'h5), "port word 0");
    rchk(OTPCS_FFRD_ADDR, pat(13'h5), "read value 0");
    rchk(OTPCS_FFPRT_ADDR, pat(13'h6), "port word 1");
    rchk(OTPCS_FFPRT_ADDR, 32'h0, "empty port");
    rchk(OTPCS_FFRD_ADDR, pat(13'h6), "read value kept");
    wr(OTPCS_IRQMSK_ADDR, 32'h0);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(OTPCS_IRQMSK_ADDR, 32'h7);
    wr(OTPCS_IRQST_ADDR, 32'h1);
    rchk(OTPCS_IRQST_ADDR, 32'h0, "irq status");
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(OTPCS_MODE_ADDR, 32'h0);
    // Auto program with a stalled cell: overfill, then drain with failures
    stall <= 1'b1;
    fail <= 1'b1;
    wr(OTPCS_CELADR_ADDR, 32'h0);
    wr(OTPCS_NWORDS_ADDR, 32'(D));
    wr(OTPCS_MODE_ADDR, 32'h2);
    for (int k = 0; k < D + 2; k++) begin
      wr(OTPCS_FFPRT_ADDR, 32'hA000_0000 + 32'(k));
    end
    rchk(OTPCS_STAT_ADDR, 32'h0005_0404, "status stalled");
    chk("word to cell", 32'hA000_0000, cell_wr_data);
    stall <= 1'b0;
    wt(OTPCS_STAT_ADDR, 32'h10, 32'h10);
    rchk(OTPCS_STAT_ADDR, 32'h0000_0017, "status programmed");
    rchk(OTPCS_NWORDS_ADDR, 32'(D), "count unchanged");
    rchk(OTPCS_CELADR_ADDR, 32'(D + 1), "cell address");
    // Port select set: count register is not used
    fail <= 1'b0;
    stall <= 1'b1;
    wr(OTPCS_MODE_ADDR, 32'h0);
    wr(OTPCS_MODE_ADDR, 32'h12);
    wr(OTPCS_FFPRT_ADDR, 32'h5555_AAAA);
    wt(OTPCS_STAT_ADDR, 32'h1, 32'h0);
    stall <= 1'b0;
    wt(OTPCS_STAT_ADDR, 32'h1, 32'h1);
    chk("program fail flag", 32'h0, st & 32'h2);
    chk("remaining kept", 32'h0, st & 32'h1FFF_0000);
    rchk(OTPCS_NWORDS_ADDR, 32'(D), "count ignored");
    // Manual program of one failing word
    fail <= 1'b1;
    wr(OTPCS_MODE_ADDR, 32'h0);
    wr(OTPCS_MODE_ADDR, 32'h3);
    wr(OTPCS_FFPRT_ADDR, 32'h0F0F_0F0F);
    wt(OTPCS_IRQST_ADDR, 32'h4, 32'h4);
    rd(OTPCS_STAT_ADDR);
    chk("manual flags", 32'h3, st & 32'h3);
    wr(OTPCS_IRQST_ADDR, 32'h4);
    wr(OTPCS_MODE_ADDR, 32'h0);
    // Blank check, decode and write tests; decode fails
    for (int m = 4; m < 7; m++) begin
      stall <= 1'b1;
      fail <= (m == 5);
      wr(OTPCS_MODE_ADDR, 32'(m));
      wt(OTPCS_STAT_ADDR, 32'h4, 32'h0);
      stall <= 1'b0;
      wt(OTPCS_IRQST_ADDR, 32'h2, 32'h2);
      rd(OTPCS_STAT_ADDR);
      chk("test flags", (m == 5) ? 32'hC : 32'h4, st & 32'hC);
      wr(OTPCS_IRQST_ADDR, 32'h2);
      wr(OTPCS_MODE_ADDR, 32'h0);
    end
    // DMA on: the port refuses software words, so the FIFO stays empty
    wr(OTPCS_MODE_ADDR, 32'hA);
    chk("dma pin", 32'h1, {31'h0, dma_enable});
    chk("mode pins", 32'h2, {29'h0, cell_mode});
    wr(OTPCS_FFPRT_ADDR, 32'h1234_5678);
    rchk(OTPCS_STAT_ADDR, 32'h0005_0005, "status dma");
    wr(OTPCS_MODE_ADDR, 32'h0);
    chk("dma pin off", 32'h0, {31'h0, dma_enable});
    wrap_up();
  end
endmodule
